// ### verilog/vsl_pkg.sv
// ----------------------------------------------------------------------------
// Shared constants and types for the variable speed limit monitor.
// ----------------------------------------------------------------------------
package vsl_pkg;

    // Width of speeds, limits and the scaling word.
    localparam int VSL_W = 16;

    // Scaling word value that stands for one hundred percent (hundredths of a percent).
    localparam logic [15:0] VSL_PCT_FULL = 16'h2710;

    // Largest scaling word the controller end will send (just under one hundred percent).
    localparam logic [15:0] VSL_PCT_MAX_SEND = 16'h270f;

    // Limit value that stands for "no limit" when a companion function is inactive.
    localparam logic [15:0] VSL_NO_LIMIT = 16'hffff;

    // Reset values of held limits and of the scaling word.
    localparam logic [15:0] VSL_RST_LIMIT = 16'h0000;
    localparam logic [15:0] VSL_RST_PCT = 16'h0000;

    // Clock period and the millisecond unit of the start delay.
    localparam int VSL_CLK_PERIOD_NS = 8;
    localparam int VSL_MS_NS = 1000000;
    localparam int VSL_MS_CYCLES = VSL_MS_NS / VSL_CLK_PERIOD_NS;

    // Supervision states of the monitor.
    typedef enum logic [1:0] {
        VSL_IDLE,
        VSL_MON,
        VSL_DOWN
    } vsl_state_t;

endpackage

// ### verilog/vsl_if.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Safety message link between the safety controller and the monitor.
// ----------------------------------------------------------------------------
interface vsl_if;
    logic msg_valid;
    logic msg_req;
    logic msg_pos_scale;
    logic msg_neg_scale;
    logic [7:0] msg_pct_hi;
    logic [7:0] msg_pct_lo;
    logic var_active;
    logic stop_active;

    // Controller end sends messages and reads back indications.
    modport ctrl (
        output msg_valid,
        output msg_req,
        output msg_pos_scale,
        output msg_neg_scale,
        output msg_pct_hi,
        output msg_pct_lo,
        input var_active,
        input stop_active
    );

    // Monitor end receives messages and reports indications.
    modport mon (
        input msg_valid,
        input msg_req,
        input msg_pos_scale,
        input msg_neg_scale,
        input msg_pct_hi,
        input msg_pct_lo,
        output var_active,
        output stop_active
    );
endinterface

// ### verilog/vsl_controller.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Safety controller end: frames scaling requests onto the link.
// ----------------------------------------------------------------------------
module vsl_controller
    import vsl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic send,
    input wire logic req_on,
    input wire logic pos_scale,
    input wire logic neg_scale,
    input wire logic [15:0] pct,
    vsl_if.ctrl lnk,
    output logic var_active_seen,
    output logic stop_seen
);

    // Scaling word is unsigned and kept below one hundred percent.
    logic [15:0] pct_clamped;
    assign pct_clamped = (pct > VSL_PCT_MAX_SEND) ? VSL_PCT_MAX_SEND : pct;

    // One message per send pulse; fields stand until the next message.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lnk.msg_valid <= 1'b0;
            lnk.msg_req <= 1'b0;
            lnk.msg_pos_scale <= 1'b0;
            lnk.msg_neg_scale <= 1'b0;
            lnk.msg_pct_hi <= VSL_RST_PCT[15:8];
            lnk.msg_pct_lo <= VSL_RST_PCT[7:0];
        end else begin
            lnk.msg_valid <= send;
            if (send) begin
                lnk.msg_req <= req_on;
                lnk.msg_pos_scale <= pos_scale;
                lnk.msg_neg_scale <= neg_scale;
                lnk.msg_pct_hi <= pct_clamped[15:8];
                lnk.msg_pct_lo <= pct_clamped[7:0];
            end
        end
    end

    // Indications returned by the monitor, registered for the user side.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            var_active_seen <= 1'b0;
            stop_seen <= 1'b0;
        end else begin
            var_active_seen <= lnk.var_active;
            stop_seen <= lnk.stop_active;
        end
    end

endmodule

// ### verilog/vsl_monitor.sv
`timescale 1ns/1ps
// What this block does
// - Speed at scaled trip limit triggers emergency stop.
// - Ramp limit hit while decelerating, with time mode off, triggers torque off.
// - Time mode: delay expiry forces checking new limits.
// - Enforce lowest of variable, fixed, maximum limits.
// - Scale base limits by percentage; hold until next.
// - Scaled limits never exceed base limit set.
// - Positive flag selects scaling of positive limits.
// - Negative flag selects scaling of negative limits independently.
// - Percentage is two bytes in hundredths percent.
// - Controller sends unsigned value below one hundred.
// - One percentage scales both enabled directions alike.
// - Acceleration ramp is not supervised.
// - Lower request: ramp drive down, start delay.
// - Ramp down: monitor new limits at midpoint.
// - Speed settled at new limit sets active flag.
// - Old limits enforced until midpoint or, in time mode, delay expiry.
// - Lower rescale before reaching limits restarts delay counter.
// - Active flag off while ramping down.
// - Higher request: accelerate, enforce new limits at once.
// - Withdrawal ends monitoring only under automatic acknowledge.
// - Acknowledge after withdrawal or a stop ends monitoring, releases drive, clears flag.
module vsl_monitor
    import vsl_pkg::*;
#(
    parameter int MS_TICK_CYCLES = VSL_MS_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    vsl_if.mon lnk,
    input wire logic signed [15:0] speed,
    input wire logic [15:0] base_limit_set_pos,
    input wire logic [15:0] base_limit_set_neg,
    input wire logic [15:0] variable_trip_limit_param_pos,
    input wire logic [15:0] variable_trip_limit_param_neg,
    input wire logic time_mode,
    input wire logic auto_ack,
    input wire logic ack,
    input wire logic ramp_hit,
    input wire logic [15:0] monitor_start_delay,
    input wire logic fixed_en,
    input wire logic [15:0] fixed_lim,
    input wire logic [15:0] fixed_trip,
    input wire logic max_en,
    input wire logic [15:0] max_lim,
    input wire logic [15:0] max_trip,
    output logic limit_req,
    output logic [15:0] drive_lim_pos,
    output logic [15:0] drive_lim_neg,
    output logic emergency_safe_stop,
    output logic torque_off,
    output logic variable_limit_active_flag,
    output logic monitoring
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------

    // Scales one base limit; unscaled when disabled, saturates at the base.
    function automatic logic [15:0] scale(input logic [15:0] base, input logic [15:0] p,
                                          input logic en);
        logic [31:0] prod;
        prod = 32'(base) * 32'(p);
        if (!en || p >= VSL_PCT_FULL) begin
            scale = base;
        end else begin
            scale = 16'(prod / 32'(VSL_PCT_FULL));
        end
    endfunction

    // Lowest of three limits.
    function automatic logic [15:0] min3(input logic [15:0] a, input logic [15:0] b,
                                         input logic [15:0] c);
        logic [15:0] m;
        m = (a < b) ? a : b;
        min3 = (m < c) ? m : c;
    endfunction

    // ------------------------------------------------------------------------
    // Held limits and state
    // ------------------------------------------------------------------------
    vsl_state_t state, next_state;
    logic [15:0] act_lim_p, act_lim_n, act_trip_p, act_trip_n;
    logic [15:0] tgt_lim_p, tgt_lim_n, tgt_trip_p, tgt_trip_n;
    logic [16:0] ms_cnt;
    logic ms_tick;
    logic [15:0] dly_cnt;
    logic withdrawn;

    // ------------------------------------------------------------------------
    // Message decode and scaling
    // ------------------------------------------------------------------------
    wire [15:0] pct = {lnk.msg_pct_hi, lnk.msg_pct_lo};
    wire req_msg = lnk.msg_valid & lnk.msg_req;
    wire wd_msg = lnk.msg_valid & ~lnk.msg_req;
    // The same percentage feeds both directions; each has its own enable.
    wire [15:0] new_lim_p = scale(base_limit_set_pos, pct, lnk.msg_pos_scale);
    wire [15:0] new_trip_p = scale(variable_trip_limit_param_pos, pct, lnk.msg_pos_scale);
    wire [15:0] new_lim_n = scale(base_limit_set_neg, pct, lnk.msg_neg_scale);
    wire [15:0] new_trip_n = scale(variable_trip_limit_param_neg, pct, lnk.msg_neg_scale);

    // When idle the unscaled set is the reference for deciding direction.
    wire idle = (state == VSL_IDLE);
    wire [15:0] cur_lim_p = idle ? base_limit_set_pos : act_lim_p;
    wire [15:0] cur_lim_n = idle ? base_limit_set_neg : act_lim_n;
    wire lower = (new_lim_p < cur_lim_p) || (new_lim_n < cur_lim_n);

    // ------------------------------------------------------------------------
    // Speed comparison against the lowest active limits
    // ------------------------------------------------------------------------
    wire spd_neg = speed[15];
    wire [16:0] spd_mag = spd_neg ? (17'h00000 - {speed[15], speed}) : {1'b0, speed};
    wire [15:0] fx_trip = fixed_en ? fixed_trip : VSL_NO_LIMIT;
    wire [15:0] mx_trip = max_en ? max_trip : VSL_NO_LIMIT;
    wire [15:0] fx_lim = fixed_en ? fixed_lim : VSL_NO_LIMIT;
    wire [15:0] mx_lim = max_en ? max_lim : VSL_NO_LIMIT;
    wire [15:0] eff_trip_p = min3(act_trip_p, fx_trip, mx_trip);
    wire [15:0] eff_trip_n = min3(act_trip_n, fx_trip, mx_trip);
    wire [15:0] eff_trip = spd_neg ? eff_trip_n : eff_trip_p;
    // Old limits stay enforced in the ramp-down state as well.
    wire trip_hit = !idle && (spd_mag >= {1'b0, eff_trip});

    // Midpoint between the new limit and the new trip limit.
    wire [16:0] mid_p = 17'(({1'b0, tgt_lim_p} + {1'b0, tgt_trip_p}) >> 1);
    wire [16:0] mid_n = 17'(({1'b0, tgt_lim_n} + {1'b0, tgt_trip_n}) >> 1);
    wire at_mid = spd_mag <= (spd_neg ? mid_n : mid_p);
    wire at_lim = spd_mag <= {1'b0, spd_neg ? act_lim_n : act_lim_p};
    wire dly_done = (dly_cnt >= monitor_start_delay);
    wire ack_ok = ack && (withdrawn || emergency_safe_stop || torque_off);

    // ------------------------------------------------------------------------
    // Supervision state machine
    // ------------------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (ack_ok) begin
            next_state = VSL_IDLE;
        end else if (wd_msg && auto_ack) begin
            next_state = VSL_IDLE;
        end else if (req_msg) begin
            next_state = lower ? VSL_DOWN : VSL_MON;
        end else if (state == VSL_DOWN && (at_mid || (time_mode && dly_done))) begin
            next_state = VSL_MON;
        end
    end

    wire take_new = (next_state == VSL_MON) && (req_msg || state == VSL_DOWN);

    // ------------------------------------------------------------------------
    // Millisecond enable and start delay counter
    // ------------------------------------------------------------------------
    assign ms_tick = (ms_cnt == 17'(MS_TICK_CYCLES - 1));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ms_cnt <= 17'h00000;
            dly_cnt <= 16'h0000;
        end else begin
            ms_cnt <= ms_tick ? 17'h00000 : ms_cnt + 17'h00001;
            if (req_msg && lower) begin
                dly_cnt <= 16'h0000;
            end else if (ms_tick && !dly_done) begin
                dly_cnt <= dly_cnt + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Limits held between messages
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tgt_lim_p <= VSL_RST_LIMIT;
            tgt_lim_n <= VSL_RST_LIMIT;
            tgt_trip_p <= VSL_RST_LIMIT;
            tgt_trip_n <= VSL_RST_LIMIT;
        end else if (req_msg) begin
            tgt_lim_p <= new_lim_p;
            tgt_lim_n <= new_lim_n;
            tgt_trip_p <= new_trip_p;
            tgt_trip_n <= new_trip_n;
        end
    end

    // Enforced limits: new at once when rising, after the ramp when falling.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            act_lim_p <= VSL_RST_LIMIT;
            act_lim_n <= VSL_RST_LIMIT;
            act_trip_p <= VSL_RST_LIMIT;
            act_trip_n <= VSL_RST_LIMIT;
        end else if (take_new && req_msg) begin
            act_lim_p <= new_lim_p;
            act_lim_n <= new_lim_n;
            act_trip_p <= new_trip_p;
            act_trip_n <= new_trip_n;
        end else if (take_new) begin
            act_lim_p <= tgt_lim_p;
            act_lim_n <= tgt_lim_n;
            act_trip_p <= tgt_trip_p;
            act_trip_n <= tgt_trip_n;
        end else if (idle && req_msg) begin
            act_lim_p <= base_limit_set_pos;
            act_lim_n <= base_limit_set_neg;
            act_trip_p <= variable_trip_limit_param_pos;
            act_trip_n <= variable_trip_limit_param_neg;
        end
    end

    // ------------------------------------------------------------------------
    // State, latched reactions and outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= VSL_IDLE;
            withdrawn <= 1'b0;
            emergency_safe_stop <= 1'b0;
            torque_off <= 1'b0;
        end else begin
            state <= next_state;
            withdrawn <= (next_state != VSL_IDLE) && (wd_msg || (withdrawn && !req_msg));
            // A hit in the acknowledge cycle still latches.
            emergency_safe_stop <= trip_hit || (emergency_safe_stop && !ack_ok);
            // Ramp supervision only while decelerating, never on acceleration.
            torque_off <= (state == VSL_DOWN && !time_mode && ramp_hit)
                          || (torque_off && !ack_ok);
        end
    end

    // Drive requests, indications and link feedback.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            limit_req <= 1'b0;
            drive_lim_pos <= VSL_RST_LIMIT;
            drive_lim_neg <= VSL_RST_LIMIT;
            variable_limit_active_flag <= 1'b0;
            monitoring <= 1'b0;
            lnk.var_active <= 1'b0;
            lnk.stop_active <= 1'b0;
        end else begin
            limit_req <= (next_state != VSL_IDLE);
            drive_lim_pos <= min3(tgt_lim_p, fx_lim, mx_lim);
            drive_lim_neg <= min3(tgt_lim_n, fx_lim, mx_lim);
            if (next_state != VSL_MON) begin
                variable_limit_active_flag <= 1'b0;
            end else if (state == VSL_MON && at_lim) begin
                variable_limit_active_flag <= 1'b1;
            end
            monitoring <= (next_state != VSL_IDLE);
            lnk.var_active <= variable_limit_active_flag;
            lnk.stop_active <= emergency_safe_stop || torque_off;
        end
    end

endmodule

// ### verif/vsl_link_properties.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Checker on the link between the controller end and the monitor end.
// ----------------------------------------------------------------------------
module vsl_link_properties
    import vsl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic msg_valid,
    input wire logic msg_req,
    input wire logic msg_pos_scale,
    input wire logic msg_neg_scale,
    input wire logic [7:0] msg_pct_hi,
    input wire logic [7:0] msg_pct_lo,
    input wire logic var_active,
    input wire logic stop_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic seen_req;
    logic prev_both;
    logic [15:0] prev_word;
    // Word on the link, and a request that cuts both scaled limits by at least a tenth.
    wire [15:0] word = {msg_pct_hi, msg_pct_lo};
    wire lower_msg = msg_valid && msg_req && msg_pos_scale && msg_neg_scale && prev_both
        && ({1'b0, word} + 17'h003e8 <= {1'b0, prev_word});

    // Remembers whether a request was ever taken and what the last message asked for.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seen_req <= 1'b0;
            prev_both <= 1'b0;
            prev_word <= VSL_PCT_FULL;
        end else if (msg_valid) begin
            seen_req <= seen_req | msg_req;
            prev_both <= msg_req & msg_pos_scale & msg_neg_scale;
            prev_word <= word;
        end
    end

    // Two cycles after a request that cuts both scaled limits, the indication is low for two cycles.
    sequence s_lower;
        lower_msg;
    endsequence
    sequence s_quiet;
        !var_active [*2];
    endsequence

    a_bytes_hold: assert property (!msg_valid |-> $stable(word))
        else $error("scaling word changed without a message");
    a_pos_hold: assert property (!msg_valid |-> $stable(msg_pos_scale))
        else $error("positive scaling bit changed without a message");
    a_neg_hold: assert property (!msg_valid |-> $stable(msg_neg_scale))
        else $error("negative scaling bit changed without a message");
    a_req_hold: assert property (!msg_valid |-> $stable(msg_req))
        else $error("request bit changed without a message");
    a_pct_range: assert property (msg_valid |-> word < VSL_PCT_FULL)
        else $error("scaling word not below one hundred percent");
    a_var_after_req: assert property ($rose(var_active) |-> $past(seen_req, 2))
        else $error("active indication rose without a request");
    a_stop_after_req: assert property ($rose(stop_active) |-> $past(seen_req, 2))
        else $error("stop rose while no limit was monitored");
    a_flag_drop: assert property (s_lower |-> ##2 s_quiet)
        else $error("active indication stayed on after a lower request");
endmodule

// ### verif/variable_speed_limit_monitor_tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Bench for the controller and the monitor joined by the link.
// ----------------------------------------------------------------------------
module variable_speed_limit_monitor_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic send = 1'b0, req_on = 1'b0, pos_scale = 1'b0, neg_scale = 1'b0;
    logic [15:0] pct = 16'h0000;
    logic signed [15:0] speed = 16'sh0000;
    logic time_mode = 1'b1, auto_ack = 1'b0, ack = 1'b0, ramp_hit = 1'b0;
    logic fixed_en = 1'b0, max_en = 1'b0;
    logic [15:0] fixed_lim = 16'hffff, max_lim = 16'hffff, fixed_trip = 16'hffff;
    logic [15:0] max_trip = 16'hffff, dly = 16'h0005;
    logic limit_req, estop, torque_off, var_flag, monitoring, var_seen, stop_seen;
    logic [15:0] lim_pos, lim_neg;
    int num_errors = 0, n_tests = 0, cycles = 0;

    vsl_if lnk ();
    vsl_controller i_vsl_controller (.clk(clk), .rst(rst), .send(send), .req_on(req_on),
        .pos_scale(pos_scale), .neg_scale(neg_scale), .pct(pct), .lnk(lnk),
        .var_active_seen(var_seen), .stop_seen(stop_seen));
    // Base limits 1000/800 and trip limits 1200/1000; one millisecond is four clocks.
    vsl_monitor #(.MS_TICK_CYCLES(4)) i_vsl_monitor (.clk(clk), .rst(rst), .lnk(lnk),
        .speed(speed), .base_limit_set_pos(16'h03e8), .base_limit_set_neg(16'h0320),
        .variable_trip_limit_param_pos(16'h04b0), .variable_trip_limit_param_neg(16'h03e8),
        .time_mode(time_mode), .auto_ack(auto_ack), .ack(ack), .ramp_hit(ramp_hit),
        .monitor_start_delay(dly), .fixed_en(fixed_en), .fixed_lim(fixed_lim),
        .fixed_trip(fixed_trip), .max_en(max_en), .max_lim(max_lim), .max_trip(max_trip),
        .limit_req(limit_req), .drive_lim_pos(lim_pos), .drive_lim_neg(lim_neg),
        .emergency_safe_stop(estop), .torque_off(torque_off),
        .variable_limit_active_flag(var_flag), .monitoring(monitoring));
    vsl_link_properties i_vsl_link_properties (.clk(clk), .rst(rst),
        .msg_valid(lnk.msg_valid), .msg_req(lnk.msg_req), .msg_pos_scale(lnk.msg_pos_scale),
        .msg_neg_scale(lnk.msg_neg_scale), .msg_pct_hi(lnk.msg_pct_hi),
        .msg_pct_lo(lnk.msg_pct_lo), .var_active(lnk.var_active),
        .stop_active(lnk.stop_active));

    // Clock of 8 ns, and a ceiling on the run length.
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // Compares of single bits and of limit values.
    task automatic chk1(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %b, seen %b", name, exp, got);
        end
    endtask
    task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    // One message through the controller, returning once the monitor has answered.
    task automatic send_msg(input logic r, input logic p, input logic n, input logic [15:0] w);
        @(posedge clk);
        send <= 1'b1;
        req_on <= r;
        pos_scale <= p;
        neg_scale <= n;
        pct <= w;
        @(posedge clk);
        send <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic pulse_ack();
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        repeat (2) @(negedge clk);
    endtask
    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence of tests.
    initial begin
        int k;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk1("monitoring", 1'b0, monitoring);
        end_test("reset");
        @(posedge clk) speed <= 16'sh0384;
        send_msg(1'b1, 1'b1, 1'b1, 16'h1388);
        chk1("monitoring", 1'b1, monitoring);
        chk1("limit_req", 1'b1, limit_req);
        chk16("lim_pos", 16'h01f4, lim_pos);
        chk16("lim_neg", 16'h0190, lim_neg);
        chk1("estop", 1'b0, estop);
        chk1("var_flag", 1'b0, var_flag);
        // A second lower request before the delay ran out must restart the delay.
        repeat (12) @(negedge clk);
        send_msg(1'b1, 1'b1, 1'b1, 16'h0fa0);
        repeat (8) @(negedge clk);
        chk1("estop", 1'b0, estop);
        for (k = 0; k < 80 && estop !== 1'b1; k++) @(negedge clk);
        chk1("estop", 1'b1, estop);
        repeat (3) @(negedge clk);
        chk1("stop_seen", 1'b1, stop_seen);
        @(posedge clk) speed <= 16'sh0000;
        send_msg(1'b0, 1'b1, 1'b1, 16'h1388);
        chk1("monitoring", 1'b1, monitoring);
        pulse_ack();
        chk1("monitoring", 1'b0, monitoring);
        chk1("estop", 1'b0, estop);
        chk1("limit_req", 1'b0, limit_req);
        end_test("time_lower");
        @(posedge clk) time_mode <= 1'b0;
        @(posedge clk) speed <= 16'sh02ee;
        send_msg(1'b1, 1'b1, 1'b1, 16'h1b58);
        repeat (4) @(posedge clk);
        ramp_hit <= 1'b1;
        repeat (3) @(negedge clk);
        chk1("torque_off", 1'b0, torque_off);
        chk1("var_flag", 1'b0, var_flag);
        @(posedge clk) speed <= 16'sh02bc;
        for (k = 0; k < 20 && var_flag !== 1'b1; k++) @(negedge clk);
        chk1("var_flag", 1'b1, var_flag);
        repeat (3) @(negedge clk);
        chk1("var_seen", 1'b1, var_seen);
        @(posedge clk) speed <= 16'sh0320;
        send_msg(1'b1, 1'b1, 1'b1, 16'h2328);
        chk16("lim_pos", 16'h0384, lim_pos);
        @(posedge clk) speed <= 16'sh03e8;
        repeat (4) @(negedge clk);
        chk1("estop", 1'b0, estop);
        chk1("torque_off", 1'b0, torque_off);
        end_test("ramp_mid_raise");
        send_msg(1'b1, 1'b1, 1'b1, 16'h1388);
        chk1("torque_off", 1'b1, torque_off);
        chk1("estop", 1'b0, estop);
        @(posedge clk) ramp_hit <= 1'b0;
        @(posedge clk) auto_ack <= 1'b1;
        send_msg(1'b0, 1'b1, 1'b1, 16'h1388);
        chk1("monitoring", 1'b0, monitoring);
        pulse_ack();
        chk1("torque_off", 1'b0, torque_off);
        end_test("torque_auto");
        @(posedge clk) speed <= 16'sh0000;
        for (k = 0; k < 4; k++) begin
            send_msg(1'b1, k[0], k[1], 16'h1388);
            chk16("lim_pos", k[0] ? 16'h01f4 : 16'h03e8, lim_pos);
            chk16("lim_neg", k[1] ? 16'h0190 : 16'h0320, lim_neg);
        end
        send_msg(1'b1, 1'b1, 1'b1, 16'hffff);
        chk16("lim_pos", 16'h03e7, lim_pos);
        chk16("lim_neg", 16'h031f, lim_neg);
        @(posedge clk);
        fixed_en <= 1'b1;
        fixed_lim <= 16'h012c;
        fixed_trip <= 16'h0190;
        repeat (3) @(negedge clk);
        chk16("lim_pos", 16'h012c, lim_pos);
        chk16("lim_neg", 16'h012c, lim_neg);
        @(posedge clk);
        max_en <= 1'b1;
        max_lim <= 16'h00c8;
        max_trip <= 16'h00fa;
        repeat (3) @(negedge clk);
        chk16("lim_pos", 16'h00c8, lim_pos);
        chk16("lim_neg", 16'h00c8, lim_neg);
        // Reverse speed above the lowest trip limit of the three functions.
        @(posedge clk) speed <= 16'shfed4;
        repeat (2) @(negedge clk);
        chk1("estop", 1'b1, estop);
        end_test("limits");
        report_and_stop();
    end
endmodule
